// ===== design/can_filter_pkg.sv
// Package for the acceptance filter control block: register map, field layout, types.
// Assumes a 32-bit APB register bus, one aligned word per register.
package can_filter_pkg;

   // ********************************
   // Register map
   // ********************************
   localparam int NUM_REGS = 8;
   localparam int FILTERS_PER_REG = 4;
   localparam int NUM_FILTERS = NUM_REGS * FILTERS_PER_REG;
   localparam logic [11:0] FILTER_CONTROL_BASE = 12'h000;
   localparam logic [11:0] FILTER_CONTROL_2_ADDR = 12'h008;
   localparam logic [11:0] FILTER_CONTROL_7_ADDR = 12'h01C;
   localparam logic [11:0] STATUS_ADDR = 12'h020;
   localparam logic [31:0] CONTROL_RESET = 32'h00000000;

   // ********************************
   // Field layout inside one byte lane
   // ********************************
   localparam int LANE_WIDTH = 8;
   localparam int ENABLE_BIT = 7;
   localparam int MASK_HI = 6;
   localparam int MASK_LO = 5;
   localparam int TARGET_HI = 4;
   localparam int TARGET_LO = 0;

   typedef enum logic [1:0] {
      mask_zero = 2'b00,
      mask_one = 2'b01,
      mask_two = 2'b10,
      mask_three = 2'b11
   } mask_choice_type;

   typedef struct packed {
      logic on;
      mask_choice_type mask_choice;
      logic [4:0] fifo_target;
   } filter_cfg_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;

endpackage

// ===== design/filter_lane.sv
// One filter's configuration byte with the enable lock.
// Assumes write strobes come from the APB slave in the same clock domain.
module filter_lane
   import can_filter_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Write side
   input wire logic write_strobe,
   input wire logic [7:0] write_byte,
   // Stored configuration
   output filter_cfg_type cfg
);

   wire logic locked;
   wire filter_cfg_type next_cfg;

   // Lock is taken from the stored enable, so a write that sets the
   // enable can still carry the new fields in the same access
   assign locked = cfg.on;
   assign next_cfg.on = write_byte[ENABLE_BIT];
   assign next_cfg.mask_choice = locked ? cfg.mask_choice
      : mask_choice_type'(write_byte[MASK_HI:MASK_LO]);
   assign next_cfg.fifo_target = locked ? cfg.fifo_target
      : write_byte[TARGET_HI:TARGET_LO];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= filter_cfg_type'(CONTROL_RESET[7:0]);
      end else if (write_strobe) begin
         cfg <= next_cfg;
      end
   end

   property p_locked_hold;
      @(posedge clk) disable iff (sys_rst)
         (write_strobe && cfg.on) |=> $stable({cfg.mask_choice, cfg.fifo_target});
   endproperty
   a_locked_hold: assert property (p_locked_hold)
      else $error("locked filter fields changed");

   property p_unlocked_load;
      @(posedge clk) disable iff (sys_rst)
         (write_strobe && !cfg.on) |=> (cfg == filter_cfg_type'($past(write_byte)));
   endproperty
   a_unlocked_load: assert property (p_unlocked_load)
      else $error("unlocked filter did not take write");

endmodule

// ===== design/can_filter_control.sv
// Acceptance filter control registers behind an APB slave, with match steering.
// Assumes an APB master on clk; match hits come from a matcher on the same clock.
//
// Summary of operation
// - Each filter has an enable bit; 1 joins acceptance, 0 removes it.
// - Mask choice 11/10/01/00 selects acceptance mask three/two/one/zero.
// - A matching message goes to the FIFO numbered by the five-bit target.
// - Mask and target fields change only while the filter is disabled.
// - Upper lane holds highest filter: enable 31, mask 30-29, target 28-24.
// - Second lane: enable 23, mask 22-21, target 20-16.
// - Lower half: odd filter at 15,14-13,12-8; even at 7,6-5,4-0.
module can_filter_control
   import can_filter_pkg::*;
#(
   parameter int FILTERS = NUM_FILTERS
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Matcher side
   input wire logic [FILTERS-1:0] filter_hit,
   output logic [FILTERS-1:0] filter_active,
   output logic [1:0] applied_mask [FILTERS],
   output logic store_valid,
   output logic [4:0] store_fifo,
   output logic [1:0] store_mask
);

   localparam int REGS = FILTERS / FILTERS_PER_REG;

   if (FILTERS % FILTERS_PER_REG != 0 || FILTERS > NUM_FILTERS || FILTERS < 4) begin : g_check
      $error("FILTERS must be a multiple of four between 4 and 32");
   end

   // ********************************
   // APB decode
   // ********************************
   function automatic logic reg_hit(input logic [11:0] addr, input int idx);
      reg_hit = (addr == FILTER_CONTROL_BASE + 12'(idx * 4));
   endfunction

   wire logic access;
   wire logic write_access;
   wire logic status_hit;
   wire logic [REGS-1:0] reg_sel;
   wire logic mapped;
   filter_cfg_type cfg [FILTERS];
   wire logic [31:0] reg_view [REGS];
   logic [31:0] next_prdata;

   assign access = psel && penable;
   assign write_access = access && pwrite;
   assign status_hit = (paddr == STATUS_ADDR);
   assign mapped = (|reg_sel) || status_hit;

   // Single-cycle access phase: no wait states ever
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // ********************************
   // Filter lanes
   // ********************************
   for (genvar r = 0; r < REGS; r++) begin : g_reg
      assign reg_sel[r] = reg_hit(paddr, r);
      for (genvar l = 0; l < FILTERS_PER_REG; l++) begin : g_lane
         // Lane l holds filter 4r+l: lane 3 at 31:24, lane 2 at 23:16,
         // lane 1 at 15:8, lane 0 at 7:0
         filter_lane filter_lane_inst (
            .clk(clk),
            .sys_rst(sys_rst),
            .write_strobe(write_access && reg_sel[r]),
            .write_byte(pwdata[l*LANE_WIDTH +: LANE_WIDTH]),
            .cfg(cfg[r*FILTERS_PER_REG + l])
         );
         assign reg_view[r][l*LANE_WIDTH +: LANE_WIDTH] = cfg[r*FILTERS_PER_REG + l];
      end
   end

   // ********************************
   // Read data
   // ********************************
   always_comb begin
      next_prdata = 32'h00000000;
      for (int r = 0; r < REGS; r++) begin
         if (reg_sel[r]) begin
            next_prdata = reg_view[r];
         end
      end
      if (status_hit) begin
         next_prdata = 32'(filter_active);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ********************************
   // Filter state towards the matcher
   // ********************************
   for (genvar f = 0; f < FILTERS; f++) begin : g_filter
      assign filter_active[f] = cfg[f].on;
      assign applied_mask[f] = cfg[f].mask_choice;
   end

   // Lowest numbered active hit wins when several filters match
   logic hit_found;
   logic [4:0] next_fifo;
   logic [1:0] next_mask;

   always_comb begin
      hit_found = 1'b0;
      next_fifo = 5'h00;
      next_mask = 2'h0;
      for (int f = FILTERS - 1; f >= 0; f--) begin
         if (filter_hit[f] && cfg[f].on) begin
            hit_found = 1'b1;
            next_fifo = cfg[f].fifo_target;
            next_mask = cfg[f].mask_choice;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         store_valid <= 1'b0;
         store_fifo <= 5'h00;
         store_mask <= 2'h0;
      end else begin
         store_valid <= hit_found;
         store_fifo <= next_fifo;
         store_mask <= next_mask;
      end
   end

   // ********************************
   // Checks
   // ********************************
   property p_disabled_no_store;
      @(posedge clk) disable iff (sys_rst)
         ((filter_hit & filter_active) == '0) |=> !store_valid;
   endproperty
   a_disabled_no_store: assert property (p_disabled_no_store)
      else $error("store without an active hit");

   property p_store_target;
      @(posedge clk) disable iff (sys_rst)
         (filter_hit[0] && cfg[0].on) |=> (store_valid && store_fifo == $past(cfg[0].fifo_target));
   endproperty
   a_store_target: assert property (p_store_target)
      else $error("wrong fifo for filter zero");

   property p_store_mask;
      @(posedge clk) disable iff (sys_rst)
         (filter_hit[0] && cfg[0].on) |=> (store_mask == $past(cfg[0].mask_choice));
   endproperty
   a_store_mask: assert property (p_store_mask)
      else $error("wrong mask for filter zero");

   sequence s_write_top(int r);
      write_access && reg_sel[r];
   endsequence

   property p_top_enable;
      @(posedge clk) disable iff (sys_rst)
         s_write_top(REGS - 1) |=> (filter_active[FILTERS-1] == $past(pwdata[31]));
   endproperty
   a_top_enable: assert property (p_top_enable)
      else $error("top enable not at bit 31");

   property p_lane2_enable;
      @(posedge clk) disable iff (sys_rst)
         s_write_top(0) |=> (filter_active[2] == $past(pwdata[23]));
   endproperty
   a_lane2_enable: assert property (p_lane2_enable)
      else $error("lane two enable not at bit 23");

   property p_lane1_enable;
      @(posedge clk) disable iff (sys_rst)
         s_write_top(0) |=> (filter_active[1] == $past(pwdata[15]) &&
                             filter_active[0] == $past(pwdata[7]));
   endproperty
   a_lane1_enable: assert property (p_lane1_enable)
      else $error("low half enables misplaced");

   property p_lock;
      @(posedge clk) disable iff (sys_rst)
         (s_write_top(0) ##0 cfg[0].on) |=> $stable(cfg[0].fifo_target);
   endproperty
   a_lock: assert property (p_lock)
      else $error("enabled filter target rewritten");

   property p_ignore;
      @(posedge clk) disable iff (sys_rst)
         (s_write_top(0) ##0 cfg[1].on) |=> $stable(cfg[1].mask_choice);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("enabled filter mask rewritten");

   sequence s_read_setup(logic [11:0] addr);
      psel && !penable && !pwrite && (paddr == addr);
   endsequence

   property p_status_read;
      @(posedge clk) disable iff (sys_rst)
         s_read_setup(STATUS_ADDR) |=> (prdata[FILTERS-1:0] == $past(filter_active));
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read does not show filter enables");

   // Top register lanes two and one, loaded while still unlocked
   property p_lane2_target;
      @(posedge clk) disable iff (sys_rst)
         (s_write_top(REGS - 1) ##0 !cfg[FILTERS-2].on)
            |=> (cfg[FILTERS-2].fifo_target == $past(pwdata[20:16]));
   endproperty
   a_lane2_target: assert property (p_lane2_target)
      else $error("lane two target not at bits 20-16");

   property p_lane1_mask;
      @(posedge clk) disable iff (sys_rst)
         (s_write_top(REGS - 1) ##0 !cfg[FILTERS-3].on)
            |=> (cfg[FILTERS-3].mask_choice == $past(pwdata[14:13]));
   endproperty
   a_lane1_mask: assert property (p_lane1_mask)
      else $error("lane one mask not at bits 14-13");

endmodule

// ===== dv/can_acceptance_filter_control_tb.sv
// Self-checking bench for the acceptance filter control block.
// Assumes the APB slave answers in its first access cycle and stores pulse one cycle.
module can_acceptance_filter_control_tb import can_filter_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, store_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [NUM_FILTERS-1:0] filter_hit, filter_active;
   logic [1:0] applied_mask [NUM_FILTERS];
   logic [4:0] store_fifo;
   logic [1:0] store_mask;
   int err_total, n_checks;
   integer seed;
   logic [32:0] rdq [$];
   logic [6:0] stq [$];

   can_filter_control #(.FILTERS(NUM_FILTERS)) can_filter_control_inst (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .filter_hit(filter_hit), .filter_active(filter_active),
      .applied_mask(applied_mask), .store_valid(store_valid),
      .store_fifo(store_fifo), .store_mask(store_mask));

   // **********
   // Tasks
   // **********
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d, errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Entered just after a rising edge; request held until pready is sampled
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rdq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic hit(input logic [31:0] v, input logic en, input logic [6:0] e);
      if (en) stq.push_back(e);
      filter_hit <= v;
      @(posedge clk);
      filter_hit <= '0;
      repeat (2) @(posedge clk);
   endtask

   // **********
   // Monitors
   // **********
   // Negedge sampling keeps clear of the edge that updates registered outputs
   always @(negedge clk) begin
      if (!sys_rst && psel && penable && !pwrite && pready)
         check({pslverr, prdata}, rdq.size() ? rdq.pop_front() : 'x);
      if (store_valid === 1'b1)
         check({26'h0, store_fifo, store_mask},
               stq.size() ? {26'h0, stq.pop_front()} : 'x);
   end

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      #(50 * 3000);
      err_total++;
      end_sim();
   end

   initial begin
      logic [31:0] cfg, nxt;
      logic [4:0] t;
      seed = 32'hC817;
      sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, filter_hit} = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // Status sits right after the last control register
      for (int r = 0; r <= NUM_REGS; r++)
         rd(FILTER_CONTROL_BASE + 12'(4 * r), {1'b0, CONTROL_RESET});
      rd(12'h024, {1'b1, 32'h0});
      cfg = '0;
      for (int l = 0; l < 4; l++) begin
         t = (l == 0) ? 5'h00 : (l == 3) ? 5'h1F : 5'($random(seed));
         cfg[8*l +: 8] = {1'b1, 2'(l), t};
      end
      apb(1'b1, FILTER_CONTROL_2_ADDR, cfg);
      rd(FILTER_CONTROL_2_ADDR, {1'b0, cfg});
      @(negedge clk);
      for (int l = 0; l < 4; l++) begin
         check({32'h0, filter_active[8+l]}, 33'h1);
         check({31'h0, applied_mask[8+l]}, 33'(l));
      end
      @(posedge clk);
      rd(STATUS_ADDR, {1'b0, 32'h00000F00});
      for (int l = 0; l < 4; l++)
         hit(32'h1 << (8 + l), 1'b1, {cfg[8*l +: 5], cfg[8*l+5 +: 2]});
      // Field writes while enabled must leave the old fields in place
      nxt = $random(seed) | 32'h80808080;
      apb(1'b1, FILTER_CONTROL_2_ADDR, nxt);
      rd(FILTER_CONTROL_2_ADDR, {1'b0, cfg});
      apb(1'b1, FILTER_CONTROL_2_ADDR, nxt & 32'h7F7F7F7F);
      rd(FILTER_CONTROL_2_ADDR, {1'b0, cfg & 32'h7F7F7F7F});
      apb(1'b1, FILTER_CONTROL_2_ADDR, nxt & 32'h7F7F7F7F);
      rd(FILTER_CONTROL_2_ADDR, {1'b0, nxt & 32'h7F7F7F7F});
      hit(32'h00000F00, 1'b0, 7'h0);
      cfg = $random(seed) | 32'h80808080;
      apb(1'b1, FILTER_CONTROL_7_ADDR, cfg);
      rd(FILTER_CONTROL_7_ADDR, {1'b0, cfg});
      hit(32'hA0000000, 1'b1, {cfg[12:8], cfg[14:13]});
      hit(32'hC0000100, 1'b1, {cfg[20:16], cfg[22:21]});
      // Register zero: load, locked rewrite, then filters 0 and 1 both hit
      cfg = $random(seed) | 32'h80808080;
      apb(1'b1, FILTER_CONTROL_BASE, cfg);
      apb(1'b1, FILTER_CONTROL_BASE, $random(seed) | 32'h80808080);
      rd(FILTER_CONTROL_BASE, {1'b0, cfg});
      hit(32'h00000003, 1'b1, {cfg[4:0], cfg[6:5]});
      // Mid-run reset must clear enabled filters
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(FILTER_CONTROL_7_ADDR, {1'b0, CONTROL_RESET});
      rd(STATUS_ADDR, {1'b0, 32'h00000000});
      check(33'(rdq.size() + stq.size()), 33'h0);
      end_sim();
   end
endmodule
